/* fcd_command_decoder.v */
// Command decoder unit of a parallel NOR flash.
// How it works
// RQ1: 0xFF selects array data on all lines.
// RQ2: 0x70 selects status on low byte.
// RQ3: Program commands switch reads to status automatically.
// RQ4: 0x90 selects identifier data on sixteen lines.
// RQ5: 0x98 selects query data on low byte.
// RQ6: 0x50 clears sticky error bits.
// RQ7: 0x40 then address/data programs one word.
// RQ8: While programming only status read/suspend accepted.
// RQ9: Host toggles select or output enable.
// RQ10: Host toggles select or address valid.
// RQ11: Host writes read-array after programming.
// RQ12: 0xE8 loads up to 512 buffer words.
// RQ13: 0xD0 confirm programs buffer into array.
// RQ14: 0x80 arms factory mode awaiting 0xD0.
// RQ15: Factory mode ignores every other command.
// RQ16: Factory confirm latches address and data; the code latches only the block address.
// RQ17: Command writes store nothing in array.
// RQ18: Program algorithm runs internally without host help.
// RQ19: Host reissues setup commands when switching die.
// RQ20: Reset gives array mode, status 0x80.
// RQ21: Write captured when write or select rises.
// RQ22: Commands from low byte; setup state tracked.
`timescale 1ns/1ps
`include "fcd_defs.vh"
module fcd_command_decoder (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Bus strobes, active low.
   input wire ceN,
   input wire weN,
   input wire oeN,
   input wire addressValidN,
   // Bus address and data.
   input wire [`FCD_AW-1:0] busAddr,
   input wire [`FCD_DW-1:0] dqIn,
   output wire [`FCD_DW-1:0] dqOut,
   output wire dqOe,
   // Read sources.
   output wire [`FCD_AW-1:0] arrayRdAddr,
   input wire [`FCD_DW-1:0] arrayRdData,
   input wire [`FCD_DW-1:0] idRdData,
   input wire [7:0] queryRdData,
   // Array program port.
   output wire arrayWrValid,
   input wire arrayWrReady,
   output wire [`FCD_AW-1:0] arrayWrAddr,
   output wire [`FCD_DW-1:0] arrayWrData,
   input wire arrayWrFail,
   // Status.
   output wire [7:0] statusReg,
   output wire factoryMode
);
   // ==========================================
   // Sequencer states, one-hot
   // ==========================================
   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_WORD = 8'h02;
   localparam [7:0] ST_BCOUNT = 8'h04;
   localparam [7:0] ST_BLOAD = 8'h08;
   localparam [7:0] ST_BCONF = 8'h10;
   localparam [7:0] ST_FSETUP = 8'h20;
   localparam [7:0] ST_FACTORY = 8'h40;
   localparam [7:0] ST_DRAIN = 8'h80;
   localparam FW = `FCD_AW + `FCD_DW;

   // ==========================================
   // Declarations
   // ==========================================
   // Sequencer state and read mode.
   reg [7:0] state_q;
   reg [7:0] state_d;
   reg [3:0] mode_q;
   reg [3:0] mode_d;
   // Sticky errors: 0 program, 1 sequence.
   reg [1:0] err_q;
   reg [1:0] errSet;
   reg errClr;
   // Address and data of the current write.
   reg [`FCD_AW-1:0] wrAddr_q;
   reg [`FCD_DW-1:0] wrData_q;
   // Program buffer and its bookkeeping.
   reg [`FCD_DW-1:0] progBuf [0:`FCD_BUF_WORDS-1];
   reg [`FCD_BUF_IW-1:0] bufLast_q;
   reg [`FCD_BUF_IW-1:0] bufLast_d;
   reg [`FCD_BUF_IW-1:0] bufIdx_q;
   reg [`FCD_BUF_IW-1:0] bufIdx_d;
   reg [`FCD_AW-1:0] bufBase_q;
   reg [`FCD_AW-1:0] bufBase_d;
   reg drainDone_q;
   reg drainDone_d;
   reg bufWrite;
   // Factory block address.
   reg [`FCD_AW-1:0] factAddr_q;
   reg [`FCD_AW-1:0] factAddr_d;
   // Registered pin and status outputs.
   reg [`FCD_DW-1:0] dqOut_q;
   reg dqOe_q;
   reg [`FCD_AW-1:0] arrayRdAddr_q;
   reg [7:0] statusReg_q;
   reg [7:0] srSnap_q;
   // FIFO feed.
   reg pushValid;
   reg [FW-1:0] pushData;
   wire pushReady;
   wire fifoEmpty;
   wire fifoOutValid;
   wire [FW-1:0] fifoOutData;
   // Strobe decode.
   wire wrActive;
   wire rdActive;
   wire wrStrobe;
   wire rdStart;
   wire advStart;
   wire busy;
   wire [7:0] cmd;
   wire [7:0] srLive;

   // ==========================================
   // Bus strobe decode
   // ==========================================
   // A write cycle ends when the first of write or select rises. RQ21
   assign wrActive = ~ceN & ~weN & oeN;
   assign rdActive = ~ceN & ~oeN & weN;
   // Command code is the low data byte. RQ22
   assign cmd = wrData_q[`FCD_CMD_MSB:0];

   fcd_edge uWrEdge (
      .clk(clk),
      .rstn(rstn),
      .level(wrActive),
      .rise(),
      .fall(wrStrobe)
   );

   fcd_edge uRdEdge (
      .clk(clk),
      .rstn(rstn),
      .level(rdActive),
      .rise(rdStart),
      .fall()
   );

   fcd_edge uAdvEdge (
      .clk(clk),
      .rstn(rstn),
      .level(~addressValidN),
      .rise(advStart),
      .fall()
   );

   // Store address and data while writing. RQ21
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrAddr_q <= {`FCD_AW{1'b0}};
         wrData_q <= {`FCD_DW{1'b0}};
      end else if (wrActive) begin
         wrAddr_q <= busAddr;
         wrData_q <= dqIn;
      end
   end

   // Busy while draining or while words still wait.
   assign busy = state_q[7] | ~fifoEmpty;
   assign srLive = {~busy, 1'b0, err_q[1], err_q[0], 4'h0};

   // ==========================================
   // Command sequencer
   // ==========================================
   // Next state, mode, error events and FIFO feed.
   always @* begin
      state_d = state_q;
      mode_d = mode_q;
      errSet = 2'b00;
      errClr = 1'b0;
      bufLast_d = bufLast_q;
      bufIdx_d = bufIdx_q;
      bufBase_d = bufBase_q;
      drainDone_d = drainDone_q;
      factAddr_d = factAddr_q;
      bufWrite = 1'b0;
      pushValid = 1'b0;
      pushData = {wrAddr_q, wrData_q};
      // A failed array write is a program error. RQ18
      if (fifoOutValid & arrayWrReady & arrayWrFail) begin
         errSet[0] = 1'b1;
      end
      case (state_q)
         ST_IDLE: begin
            if (wrStrobe & busy) begin
               // Only status read and suspend pass while programming. RQ8
               if (cmd == `FCD_CMD_READ_STATUS || cmd == `FCD_CMD_SUSPEND) begin
                  mode_d = `FCD_MODE_STATUS;
               end
            end else if (wrStrobe) begin
               // Commands store nothing in the array. RQ17
               case (cmd)
                  `FCD_CMD_READ_ARRAY: mode_d = `FCD_MODE_ARRAY; // RQ1
                  `FCD_CMD_READ_STATUS: mode_d = `FCD_MODE_STATUS; // RQ2
                  `FCD_CMD_READ_ID: mode_d = `FCD_MODE_ID; // RQ4
                  `FCD_CMD_READ_QUERY: mode_d = `FCD_MODE_QUERY; // RQ5
                  `FCD_CMD_CLEAR_STATUS: errClr = 1'b1; // RQ6
                  `FCD_CMD_WORD_PROG: begin
                     state_d = ST_WORD; // RQ7
                     mode_d = `FCD_MODE_STATUS; // RQ3
                  end
                  `FCD_CMD_BUF_PROG: begin
                     state_d = ST_BCOUNT; // RQ12
                     mode_d = `FCD_MODE_STATUS; // RQ3
                  end
                  `FCD_CMD_FACTORY: begin
                     state_d = ST_FSETUP; // RQ14
                     mode_d = `FCD_MODE_STATUS; // RQ3
                  end
                  default: begin
                     // Unknown codes are ignored.
                     mode_d = mode_q;
                  end
               endcase
            end
         end
         ST_WORD: begin
            // Second cycle: address and data go to the array. RQ7
            if (wrStrobe) begin
               pushValid = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_BCOUNT: begin
            // Data holds the word count minus one, so 512 at most. RQ12
            if (wrStrobe) begin
               bufLast_d = wrData_q[`FCD_BUF_IW-1:0];
               bufIdx_d = {`FCD_BUF_IW{1'b0}};
               state_d = ST_BLOAD;
            end
         end
         ST_BLOAD: begin
            // Words fill the buffer; first address is base. RQ12
            if (wrStrobe) begin
               bufWrite = 1'b1;
               if (bufIdx_q == {`FCD_BUF_IW{1'b0}}) begin
                  bufBase_d = wrAddr_q;
               end
               bufIdx_d = bufIdx_q + 1'b1;
               if (bufIdx_q == bufLast_q) begin
                  state_d = ST_BCONF;
               end
            end
         end
         ST_BCONF: begin
            // Confirm starts the internal buffer program. RQ13
            if (wrStrobe) begin
               bufIdx_d = {`FCD_BUF_IW{1'b0}};
               drainDone_d = 1'b0;
               if (cmd == `FCD_CMD_CONFIRM) begin
                  state_d = ST_DRAIN;
               end else begin
                  errSet = 2'b11;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_FSETUP: begin
            // Confirm latches the block, enters factory mode. RQ14 RQ16
            if (wrStrobe) begin
               if (cmd == `FCD_CMD_CONFIRM) begin
                  factAddr_d = wrAddr_q;
                  state_d = ST_FACTORY;
               end else begin
                  errSet = 2'b11;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_FACTORY: begin
            // Writes in the block are data, never commands. RQ15
            if (wrStrobe) begin
               if (wrAddr_q[`FCD_BLK_MSB:`FCD_BLK_LSB] != factAddr_q[`FCD_BLK_MSB:`FCD_BLK_LSB]) begin
                  state_d = ST_IDLE;
               end else if (pushReady) begin
                  pushValid = 1'b1;
               end else begin
                  errSet[0] = 1'b1;
               end
            end
         end
         ST_DRAIN: begin
            // Buffer words enter the FIFO. RQ13 RQ18
            pushData = {bufBase_q + {{(`FCD_AW-`FCD_BUF_IW){1'b0}}, bufIdx_q}, progBuf[bufIdx_q]};
            if (!drainDone_q) begin
               pushValid = 1'b1;
               if (pushReady) begin
                  bufIdx_d = bufIdx_q + 1'b1;
                  drainDone_d = (bufIdx_q == bufLast_q);
               end
            end else begin
               state_d = ST_IDLE;
            end
            // Only status read and suspend pass. RQ8
            if (wrStrobe && (cmd == `FCD_CMD_READ_STATUS || cmd == `FCD_CMD_SUSPEND)) begin
               mode_d = `FCD_MODE_STATUS;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Buffer storage, no reset.
   always @(posedge clk) begin
      if (bufWrite) begin
         progBuf[bufIdx_q] <= wrData_q;
      end
   end

   // Sequencer registers; reset gives array mode and status 0x80. RQ20
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         mode_q <= `FCD_MODE_ARRAY;
         err_q <= 2'b00;
         bufLast_q <= {`FCD_BUF_IW{1'b0}};
         bufIdx_q <= {`FCD_BUF_IW{1'b0}};
         bufBase_q <= {`FCD_AW{1'b0}};
         drainDone_q <= 1'b0;
         factAddr_q <= {`FCD_AW{1'b0}};
         statusReg_q <= `FCD_SR_RESET;
      end else begin
         state_q <= state_d;
         mode_q <= mode_d;
         // A new error wins over a clear in the same cycle. RQ6
         err_q <= (err_q & ~{2{errClr}}) | errSet;
         bufLast_q <= bufLast_d;
         bufIdx_q <= bufIdx_d;
         bufBase_q <= bufBase_d;
         drainDone_q <= drainDone_d;
         factAddr_q <= factAddr_d;
         statusReg_q <= srLive;
      end
   end

   // ==========================================
   // Program FIFO
   // ==========================================
   fcd_fifo #(
      .WIDTH(FW),
      .DEPTH(`FCD_FIFO_DEPTH),
      .AW(`FCD_FIFO_AW)
   ) uFifo (
      .clk(clk),
      .rstn(rstn),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushData),
      .outValid(fifoOutValid),
      .outReady(arrayWrReady),
      .outData(fifoOutData),
      .empty(fifoEmpty)
   );

   // ==========================================
   // Read path
   // ==========================================
   // Snapshot refreshes on a new read or address valid. RQ9 RQ10
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         srSnap_q <= `FCD_SR_RESET;
      end else if (rdStart | advStart) begin
         srSnap_q <= statusReg_q;
      end
   end

   // Read data by mode.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dqOut_q <= {`FCD_DW{1'b0}};
         dqOe_q <= 1'b0;
         arrayRdAddr_q <= {`FCD_AW{1'b0}};
      end else begin
         dqOe_q <= rdActive;
         arrayRdAddr_q <= busAddr;
         case (mode_q)
            `FCD_MODE_ARRAY: dqOut_q <= arrayRdData; // RQ1
            `FCD_MODE_STATUS: dqOut_q <= {8'h00, srSnap_q}; // RQ2
            `FCD_MODE_ID: dqOut_q <= idRdData; // RQ4
            `FCD_MODE_QUERY: dqOut_q <= {8'h00, queryRdData}; // RQ5
            default: dqOut_q <= arrayRdData;
         endcase
      end
   end

   assign dqOut = dqOut_q;
   assign dqOe = dqOe_q;
   assign arrayRdAddr = arrayRdAddr_q;
   assign arrayWrValid = fifoOutValid;
   assign arrayWrAddr = fifoOutData[FW-1:`FCD_DW];
   assign arrayWrData = fifoOutData[`FCD_DW-1:0];
   assign statusReg = statusReg_q;
   assign factoryMode = state_q[6];
endmodule

/* fcd_defs.vh */
// Shared constants of the flash command decoder.
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH
// ==========================================
// Widths and sizes
// ==========================================
`define FCD_AW 24
`define FCD_DW 16
`define FCD_BLK_MSB 23
`define FCD_BLK_LSB 16
`define FCD_CMD_MSB 7
`define FCD_BUF_WORDS 512
`define FCD_BUF_IW 9
`define FCD_FIFO_DEPTH 16
`define FCD_FIFO_AW 4
// ==========================================
// Command codes
// ==========================================
`define FCD_CMD_READ_ARRAY 8'hff
`define FCD_CMD_READ_STATUS 8'h70
`define FCD_CMD_READ_ID 8'h90
`define FCD_CMD_READ_QUERY 8'h98
`define FCD_CMD_CLEAR_STATUS 8'h50
`define FCD_CMD_WORD_PROG 8'h40
`define FCD_CMD_BUF_PROG 8'he8
`define FCD_CMD_FACTORY 8'h80
`define FCD_CMD_CONFIRM 8'hd0
`define FCD_CMD_SUSPEND 8'hb0
// ==========================================
// Status register layout
// ==========================================
`define FCD_SR_RESET 8'h80
`define FCD_SR_READY 7
`define FCD_SR_ERASE_ERR 5
`define FCD_SR_PROG_ERR 4
// ==========================================
// Read modes, one-hot
// ==========================================
`define FCD_MODE_ARRAY 4'h1
`define FCD_MODE_STATUS 4'h2
`define FCD_MODE_ID 4'h4
`define FCD_MODE_QUERY 4'h8
`endif

/* fcd_edge.v */
// Edge detector for one sampled level.
`timescale 1ns/1ps
module fcd_edge (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Level to watch.
   input wire level,
   // One-cycle edge pulses.
   output wire rise,
   output wire fall
);
   // Level as seen on the previous edge.
   reg level_q;

   // Last level; reset gives the idle low.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level;
      end
   end

   // Pulses last exactly one cycle.
   assign rise = level & ~level_q;
   assign fall = ~level & level_q;
endmodule

/* fcd_fifo.v */
// FIFO with a registered output stage.
`timescale 1ns/1ps
module fcd_fifo #(
   parameter WIDTH = 40,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Filling side.
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // Draining side.
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData,
   // Nothing stored and nothing offered.
   output wire empty
);
   // Depth at the counter width.
   localparam [AW:0] DEPTH_C = DEPTH;
   // Storage array.
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   // Pointers and fill count.
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   // Output stage.
   reg [WIDTH-1:0] outData_q;
   reg outValid_q;
   wire push;
   wire load;

   assign inReady = count_q < DEPTH_C;
   assign push = inValid & inReady;
   // Refill the output stage when free or taken.
   assign load = (count_q != {(AW+1){1'b0}}) & (~outValid_q | outReady);

   // Storage, no reset.
   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // Pointers, count, output stage.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         outData_q <= {WIDTH{1'b0}};
         outValid_q <= 1'b0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (load) begin
            rdPtr_q <= rdPtr_q + 1'b1;
            outData_q <= mem[rdPtr_q];
            outValid_q <= 1'b1;
         end else if (outReady) begin
            outValid_q <= 1'b0;
         end
         // Count changes only when exactly one of push and load happens.
         if (push & ~load) begin
            count_q <= count_q + 1'b1;
         end else if (load & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   assign outValid = outValid_q;
   assign outData = outData_q;
   assign empty = (count_q == {(AW+1){1'b0}}) & ~outValid_q;
endmodule

/* fcd_array_model.sv */
// Array model behind the decoder's array port.
`timescale 1ns/1ps
`include "fcd_defs.vh"
module fcd_array_model #(
   // Identifier word; the value is arbitrary.
   parameter ID_WORD = 16'h5a3c
) (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Bench controls for slow and failing answers.
   input wire stallReq,
   input wire failReq,
   // Read sources.
   input wire [`FCD_AW-1:0] arrayRdAddr,
   output wire [`FCD_DW-1:0] arrayRdData,
   output wire [`FCD_DW-1:0] idRdData,
   output wire [7:0] queryRdData,
   // Program port.
   input wire arrayWrValid,
   output wire arrayWrReady,
   input wire [`FCD_AW-1:0] arrayWrAddr,
   input wire [`FCD_DW-1:0] arrayWrData,
   output wire arrayWrFail,
   // Log of the words taken.
   output reg [15:0] wordCount,
   output reg [`FCD_AW-1:0] lastAddr,
   output reg [`FCD_DW-1:0] lastData
);
   // Array data follows the address.
   assign arrayRdData = {arrayRdAddr[7:0], ~arrayRdAddr[7:0]};
   assign idRdData = ID_WORD;
   assign queryRdData = arrayRdAddr[7:0] + 8'h10;
   // Stall and failure come from the bench.
   assign arrayWrReady = !stallReq;
   assign arrayWrFail = failReq;
   // Each word taken is logged.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wordCount <= 16'h0000;
         lastAddr <= 24'h000000;
         lastData <= 16'h0000;
      end else if (arrayWrValid && arrayWrReady) begin
         wordCount <= wordCount + 16'h0001;
         lastAddr <= arrayWrAddr;
         lastData <= arrayWrData;
      end
   end
endmodule

/* fcd_command_decoder_monitor.sv */
// Port assertions of the flash command decoder.
`timescale 1ns/1ps
`include "fcd_defs.vh"
module fcd_command_decoder_monitor (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Bus strobes and data.
   input wire ceN,
   input wire weN,
   input wire oeN,
   input wire [`FCD_DW-1:0] dqIn,
   input wire dqOe,
   // Array port.
   input wire arrayWrValid,
   input wire arrayWrReady,
   input wire [`FCD_AW-1:0] arrayWrAddr,
   input wire [`FCD_DW-1:0] arrayWrData,
   input wire arrayWrFail,
   // Status.
   input wire [7:0] statusReg,
   input wire factoryMode
);
   // Host write in progress.
   wire wrAct = !ceN && !weN && oeN;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // A word offered but not taken.
   sequence stallSeq;
      arrayWrValid && !arrayWrReady;
   endsequence
   // A host read held over two edges.
   sequence readSeq;
      (!ceN && !oeN && weN) [*2];
   endsequence
   reset_values_a: assert property ($rose(rstn) |-> statusReg == `FCD_SR_RESET && !factoryMode && !arrayWrValid)
      else $error("reset values wrong");
   status_zero_bits_a: assert property (statusReg[6] == 1'b0 && statusReg[3:0] == 4'h0)
      else $error("unused status bits set");
   drive_on_read_a: assert property (readSeq |-> dqOe)
      else $error("data not driven");
   word_held_a: assert property (stallSeq |=> arrayWrValid && $stable(arrayWrAddr) && $stable(arrayWrData))
      else $error("stalled word changed");
   busy_while_stalled_a: assert property (stallSeq |=> ##[0:1] !statusReg[`FCD_SR_READY])
      else $error("ready while word pending");
   fail_sets_error_a: assert property (arrayWrValid && arrayWrReady && arrayWrFail |-> ##[1:3] statusReg[4])
      else $error("program error not set");
   factory_entry_a: assert property ($rose(factoryMode) |->
      ($past(wrAct, 2) && $past(dqIn[7:0], 2) == `FCD_CMD_CONFIRM) ||
      ($past(wrAct, 3) && $past(dqIn[7:0], 3) == `FCD_CMD_CONFIRM))
      else $error("factory without confirm");
   factory_stays_a: assert property (factoryMode && !wrAct && !$past(wrAct) && !$past(wrAct, 2) |=> factoryMode)
      else $error("factory mode left");
endmodule
bind fcd_command_decoder fcd_command_decoder_monitor mon (.clk(clk), .rstn(rstn), .ceN(ceN), .weN(weN), .oeN(oeN),
   .dqIn(dqIn), .dqOe(dqOe), .arrayWrValid(arrayWrValid), .arrayWrReady(arrayWrReady), .arrayWrAddr(arrayWrAddr),
   .arrayWrData(arrayWrData), .arrayWrFail(arrayWrFail), .statusReg(statusReg), .factoryMode(factoryMode));

/* flash_command_decoder_test.sv */
// Bench for the flash command decoder.
`timescale 1ns/1ps
`include "fcd_defs.vh"
module flash_command_decoder_test;
   // ==========
   // Signals
   // ==========================================
   localparam [15:0] ID = 16'h5a3c; // Arbitrary identifier word.
   reg clk = 1'b0, rstn = 1'b0, stallReq = 1'b0, failReq = 1'b0;
   reg ceN = 1'b1, weN = 1'b1, oeN = 1'b1, addressValidN = 1'b1;
   reg [`FCD_AW-1:0] busAddr = 24'h000000;
   reg [`FCD_DW-1:0] dqIn = 16'h0000;
   wire [`FCD_DW-1:0] dqOut, arrayRdData, idRdData, arrayWrData, lastData;
   wire [`FCD_AW-1:0] arrayRdAddr, arrayWrAddr, lastAddr;
   wire [7:0] queryRdData, statusReg;
   wire [15:0] wordCount;
   wire dqOe, arrayWrValid, arrayWrReady, arrayWrFail, factoryMode;
   integer num_errors = 0, n_compared = 0, i, base;
   reg [15:0] rdData;
   // Table rows: mode command, read address, expected word.
   reg [7:0] rowCmd [0:4] = '{8'hff, 8'h70, 8'h90, 8'h98, 8'hff};
   reg [23:0] rowAddr [0:4] = '{24'h000012, 24'h000012, 24'h000000, 24'h000012, 24'h000034};
   reg [15:0] rowExp [0:4] = '{16'h12ed, 16'h0080, ID, 16'h0022, 16'h34cb};
   // ==========
   // Design and array model
   // ==========================================
   fcd_command_decoder DUT (.clk(clk), .rstn(rstn), .ceN(ceN), .weN(weN), .oeN(oeN), .addressValidN(addressValidN),
      .busAddr(busAddr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .arrayRdAddr(arrayRdAddr),
      .arrayRdData(arrayRdData), .idRdData(idRdData), .queryRdData(queryRdData), .arrayWrValid(arrayWrValid),
      .arrayWrReady(arrayWrReady), .arrayWrAddr(arrayWrAddr), .arrayWrData(arrayWrData),
      .arrayWrFail(arrayWrFail), .statusReg(statusReg), .factoryMode(factoryMode));
   fcd_array_model #(.ID_WORD(ID)) model (.clk(clk), .rstn(rstn), .stallReq(stallReq), .failReq(failReq),
      .arrayRdAddr(arrayRdAddr), .arrayRdData(arrayRdData), .idRdData(idRdData), .queryRdData(queryRdData),
      .arrayWrValid(arrayWrValid), .arrayWrReady(arrayWrReady), .arrayWrAddr(arrayWrAddr),
      .arrayWrData(arrayWrData), .arrayWrFail(arrayWrFail), .wordCount(wordCount), .lastAddr(lastAddr),
      .lastData(lastData));
   // ==========
   // Tasks
   // ==========
   // Waits n edges, then 2 ns more.
   task idle(input integer n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Compares one value.
   task check(input string what, input [15:0] exp, input [15:0] got);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One write cycle.
   task bus_write(input [23:0] a, input [15:0] d);
      ceN = 1'b0;
      weN = 1'b0;
      busAddr = a;
      dqIn = d;
      idle(1);
      ceN = 1'b1;
      weN = 1'b1;
      idle(2);
   endtask
   // One read; selecting refreshes status.
   task bus_read(input [23:0] a);
      ceN = 1'b0;
      oeN = 1'b0;
      addressValidN = 1'b0;
      busAddr = a;
      idle(4);
      rdData = dqOut;
      check("read drive", 16'h0001, {15'h0000, dqOe});
      ceN = 1'b1;
      oeN = 1'b1;
      addressValidN = 1'b1;
      idle(1);
   endtask
   // Waits until n more words reached the array.
   task wait_words(input integer n);
      integer k;
      k = 0;
      while (wordCount < base + n && k < 300) begin
         idle(1);
         k = k + 1;
      end
      check("words taken", 16'h0001, {15'h0000, k < 300});
      idle(4);
   endtask
   // Prints the verdict.
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ==========
   // Clock, watchdog and tests
   // ==========
   initial begin
      forever #25 clk = ~clk;
   end
   // Ends a hang; the tests need a few hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors = num_errors + 1;
      finish_test;
   end
   initial begin
      idle(4);
      rstn = 1'b1;
      idle(2);
      check("reset status", 16'h0080, {8'h00, statusReg});
      bus_read(24'h000012);
      check("reset array", 16'h12ed, rdData);
      $display("test reset done");
      for (i = 0; i < 5; i = i + 1) begin
         bus_write(24'h000000, {8'h00, rowCmd[i]});
         bus_read(rowAddr[i]);
         check("mode read", rowExp[i], rdData);
      end
      $display("test modes done");
      base = wordCount;
      stallReq = 1'b1;
      bus_write(24'h000000, 16'h0040);
      bus_write(24'h000100, 16'hbeef);
      idle(4);
      bus_read(24'h000000);
      check("busy status", 16'h0000, rdData);
      bus_write(24'h000000, 16'h00ff);
      bus_read(24'h000000);
      check("busy ignores", 16'h0000, rdData);
      stallReq = 1'b0;
      wait_words(1);
      check("word addr", 16'h0100, lastAddr[15:0]);
      check("word data", 16'hbeef, lastData);
      bus_read(24'h000000);
      check("stays status", 16'h0080, rdData);
      $display("test word program done");
      base = wordCount;
      failReq = 1'b1;
      bus_write(24'h000000, 16'h0040);
      bus_write(24'h000102, 16'h1234);
      wait_words(1);
      failReq = 1'b0;
      check("fail status", 16'h0090, {8'h00, statusReg});
      bus_write(24'h000000, 16'h0050);
      check("cleared", 16'h0080, {8'h00, statusReg});
      $display("test program fail done");
      base = wordCount;
      bus_write(24'h000200, 16'h00e8);
      bus_write(24'h000200, 16'h0002);
      for (i = 0; i < 3; i = i + 1)
         bus_write(24'h000200 + i[23:0], 16'ha000 + i[15:0]);
      bus_write(24'h000200, 16'h00d0);
      wait_words(3);
      check("buffer addr", 16'h0202, lastAddr[15:0]);
      check("buffer data", 16'ha002, lastData);
      idle(8);
      check("buffer count", 16'h0003, wordCount - base[15:0]);
      bus_write(24'h000000, 16'h00e8);
      bus_write(24'h000300, 16'h0000);
      bus_write(24'h000300, 16'h5555);
      bus_write(24'h000000, 16'h00ff);
      idle(8);
      check("abort status", 16'h00b0, {8'h00, statusReg});
      bus_write(24'h000000, 16'h0050);
      check("abort cleared", 16'h0080, {8'h00, statusReg});
      $display("test buffer done");
      base = wordCount;
      bus_write(24'h000000, 16'h0080);
      bus_write(24'h030000, 16'h00d0);
      check("factory on", 16'h0001, {15'h0000, factoryMode});
      bus_write(24'h030005, 16'h00ff);
      wait_words(1);
      check("factory data", 16'h00ff, lastData);
      check("factory kept", 16'h0001, {15'h0000, factoryMode});
      base = wordCount;
      stallReq = 1'b1;
      for (i = 0; i < 20; i = i + 1)
         bus_write(24'h030000, 16'h0100 + i[15:0]);
      check("overflow error", 16'h0001, {15'h0000, statusReg[4]});
      stallReq = 1'b0;
      wait_words(16);
      idle(8);
      check("fifo words", 16'h0011, wordCount - base[15:0]);
      bus_write(24'h040000, 16'h0000);
      check("factory left", 16'h0000, {15'h0000, factoryMode});
      bus_write(24'h000000, 16'h0050);
      check("factory cleared", 16'h0080, {8'h00, statusReg});
      $display("test factory done");
      finish_test;
   end
endmodule
